// ===== include/mlf_pkg.sv
package mlf_pkg;

    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO  = 8'hEB;

    localparam logic [4:0] ADDR_BITS      = 5'h18;
    localparam logic [4:0] FIELD_BITS     = 5'h08;
    localparam logic [4:0] OPC_CLKS_SERIAL = 5'h08;
    localparam logic [4:0] OPC_CLKS_FOUR  = 5'h02;
    localparam logic [4:0] DUMMY_OUT_CLKS = 5'h08;
    localparam logic [4:0] DUMMY_QIO_CLKS = 5'h04;
    localparam logic [1:0] CONT_CODE      = 2'h2;

    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STAT    = 8'h04;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    localparam int unsigned CTRL_QE_BIT    = 0;
    localparam int unsigned CTRL_FOUR_BIT  = 1;
    localparam int unsigned CTRL_WRAP_LSB  = 4;
    localparam int unsigned CTRL_DSEL_LSB  = 8;
    localparam int unsigned STAT_CONT_BIT  = 4;
    localparam int unsigned STAT_ACT_BIT   = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_OPC   = 3'h1,
        ST_ADDR  = 3'h3,
        ST_FIELD = 3'h2,
        ST_DUMMY = 3'h6,
        ST_DATA  = 3'h7,
        ST_SKIP  = 3'h5
    } mlf_state_t;

    typedef enum logic [1:0] {
        CMD_DUAL_OUT = 2'h0,
        CMD_QUAD_OUT = 2'h1,
        CMD_DUAL_IO  = 2'h2,
        CMD_QUAD_IO  = 2'h3
    } mlf_cmd_t;

    typedef struct packed {
        logic [1:0] dummy_sel;
        logic [2:0] wrap_config_bits;
        logic       four_lane_command_mode;
        logic       quad_lane_enable;
    } mlf_cfg_t;

    localparam mlf_cfg_t CFG_RST = '{
        dummy_sel:              2'h0,
        wrap_config_bits:       3'h1,
        four_lane_command_mode: 1'h0,
        quad_lane_enable:       1'h0
    };

endpackage

// ===== verilog/mlf_read_path.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module mlf_read_path (
    // Clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          srst_i,
    // Serial link pins
    input  wire logic                          sclk_i,
    input  wire logic                          cs_n_i,
    input  wire logic [3:0]                    io_i,
    output logic      [3:0]                    io_o,
    output logic      [3:0]                    io_oe_o,
    // Array read port, data valid one cycle after address
    output logic      [23:0]                   mem_addr_o,
    input  wire logic [7:0]                    mem_rdata_i,
    // AXI4-Lite write channels
    input  wire logic [mlf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                          s_axi_awvalid_i,
    output logic                               s_axi_awready_o,
    input  wire logic [31:0]                   s_axi_wdata_i,
    input  wire logic [3:0]                    s_axi_wstrb_i,
    input  wire logic                          s_axi_wvalid_i,
    output logic                               s_axi_wready_o,
    output logic      [1:0]                    s_axi_bresp_o,
    output logic                               s_axi_bvalid_o,
    input  wire logic                          s_axi_bready_i,
    // AXI4-Lite read channels
    input  wire logic [mlf_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                          s_axi_arvalid_i,
    output logic                               s_axi_arready_o,
    output logic      [31:0]                   s_axi_rdata_o,
    output logic      [1:0]                    s_axi_rresp_o,
    output logic                               s_axi_rvalid_o,
    input  wire logic                          s_axi_rready_i
);
    import mlf_pkg::*;

    function automatic logic [2:0] in_lanes(mlf_cmd_t c);
        case (c)
            CMD_DUAL_IO: in_lanes = 3'h2;
            CMD_QUAD_IO: in_lanes = 3'h4;
            default:     in_lanes = 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] out_lanes(mlf_cmd_t c);
        case (c)
            CMD_QUAD_OUT: out_lanes = 3'h4;
            CMD_QUAD_IO:  out_lanes = 3'h4;
            default:      out_lanes = 3'h2;
        endcase
    endfunction

    function automatic logic [4:0] clks_for(logic [4:0] bits,
                                            logic [2:0] n);
        case (n)
            3'h4:    clks_for = bits >> 2;
            3'h2:    clks_for = bits >> 1;
            default: clks_for = bits;
        endcase
    endfunction

    // The highest lane always takes the most significant bits.
    function automatic logic [23:0] shift_in(logic [23:0] s,
                                             logic [3:0]  d,
                                             logic [2:0]  n);
        case (n)
            3'h4:    shift_in = {s[19:0], d};
            3'h2:    shift_in = {s[21:0], d[1:0]};
            default: shift_in = {s[22:0], d[0]};
        endcase
    endfunction

    function automatic logic [3:0] top_bits(logic [7:0] b,
                                            logic [2:0] n);
        case (n)
            3'h4:    top_bits = b[7:4];
            3'h2:    top_bits = {2'h0, b[7:6]};
            default: top_bits = {3'h0, b[7]};
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(logic [2:0] n);
        case (n)
            3'h4:    lane_mask = 4'hF;
            3'h2:    lane_mask = 4'h3;
            default: lane_mask = 4'h1;
        endcase
    endfunction

    // Wrapping keeps the upper address bits and rolls the low ones.
    function automatic logic [23:0] next_addr(logic [23:0] a,
                                              logic        wrap,
                                              logic [1:0]  len);
        logic [23:0] inc;
        inc = a + 24'h1;
        if (!wrap) begin
            next_addr = inc;
        end else begin
            case (len)
                2'h0:    next_addr = {a[23:3], inc[2:0]};
                2'h1:    next_addr = {a[23:4], inc[3:0]};
                2'h2:    next_addr = {a[23:5], inc[4:0]};
                default: next_addr = {a[23:6], inc[5:0]};
            endcase
        end
    endfunction

    logic [2:0]  sclk_s_q;
    logic [1:0]  cs_n_s_q;
    logic [3:0]  io_s1_q;
    logic [3:0]  io_s2_q;
    mlf_cfg_t    cfg_q;
    mlf_state_t  state_q;
    mlf_cmd_t    cmd_q;
    logic [4:0]  cnt_q;
    logic [23:0] sh_q;
    logic [23:0] addr_q;
    logic        cont_q;
    logic [7:0]  obuf_q;
    logic [2:0]  ocnt_q;
    logic [3:0]  io_q;
    logic [3:0]  oe_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;

    logic        rise;
    logic        fall;
    logic        cs_act;
    logic        four;
    logic        wrap_on;
    logic [2:0]  lanes_n;
    logic [2:0]  dl;
    logic [23:0] sh_n;
    logic [4:0]  cnt_n;
    logic [4:0]  plen;
    logic [4:0]  dummy_len;
    logic        phase_end;
    logic        op_ok;
    mlf_cmd_t    op_cmd;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] ctrl_w;
    logic [31:0] stat_w;

    // The first stage of each synchroniser feeds only the second.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sclk_s_q <= 3'h0;
            cs_n_s_q <= 2'h3;
            io_s1_q  <= 4'h0;
            io_s2_q  <= 4'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            cs_n_s_q <= {cs_n_s_q[0], cs_n_i};
            io_s1_q  <= io_i;
            io_s2_q  <= io_s1_q;
        end
    end

    assign rise   = sclk_s_q[1] & ~sclk_s_q[2];
    assign fall   = ~sclk_s_q[1] & sclk_s_q[2];
    assign cs_act = ~cs_n_s_q[1];
    assign four   = cfg_q.four_lane_command_mode;
    assign dl     = out_lanes(cmd_q);
    assign wrap_on = (cmd_q == CMD_QUAD_IO) && !four
                     && !cfg_q.wrap_config_bits[0];

    always_comb begin
        lanes_n = (state_q == ST_OPC) ? (four ? 3'h4 : 3'h1)
                                      : in_lanes(cmd_q);
        sh_n  = shift_in(sh_q, io_s2_q, lanes_n);
        cnt_n = cnt_q + 5'h1;
        case (cmd_q)
            CMD_DUAL_IO: dummy_len = 5'h0;
            CMD_QUAD_IO: dummy_len = four ?
                {2'h0, cfg_q.dummy_sel, 1'h0} :
                DUMMY_QIO_CLKS;
            default:     dummy_len = DUMMY_OUT_CLKS;
        endcase
        case (state_q)
            ST_OPC:   plen = four ? OPC_CLKS_FOUR : OPC_CLKS_SERIAL;
            ST_ADDR:  plen = clks_for(ADDR_BITS, lanes_n);
            ST_FIELD: plen = clks_for(FIELD_BITS, lanes_n);
            ST_DUMMY: plen = dummy_len;
            default:  plen = 5'h0;
        endcase
        phase_end = (cnt_n == plen);
    end

    // Opcodes outside this read path are left to run to select high.
    always_comb begin
        op_ok  = 1'b0;
        op_cmd = CMD_DUAL_OUT;
        case (sh_n[7:0])
            OP_DUAL_OUT: begin
                op_ok  = !four;
                op_cmd = CMD_DUAL_OUT;
            end
            OP_QUAD_OUT: begin
                op_ok  = !four && cfg_q.quad_lane_enable;
                op_cmd = CMD_QUAD_OUT;
            end
            OP_DUAL_IO: begin
                op_ok  = !four;
                op_cmd = CMD_DUAL_IO;
            end
            OP_QUAD_IO: begin
                op_ok  = cfg_q.quad_lane_enable;
                op_cmd = CMD_QUAD_IO;
            end
            default: begin
                op_ok  = 1'b0;
                op_cmd = CMD_DUAL_OUT;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_DUAL_OUT;
            cnt_q   <= 5'h0;
        end else if (!cs_act) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h0;
        end else if (state_q == ST_IDLE) begin
            state_q <= cont_q ? ST_ADDR : ST_OPC;
            cnt_q   <= 5'h0;
        end else if (rise) begin
            cnt_q <= cnt_n;
            case (state_q)
                ST_OPC: begin
                    if (phase_end) begin
                        cnt_q   <= 5'h0;
                        cmd_q   <= op_cmd;
                        state_q <= op_ok ? ST_ADDR : ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    if (phase_end) begin
                        cnt_q   <= 5'h0;
                        state_q <= (cmd_q == CMD_DUAL_IO ||
                                    cmd_q == CMD_QUAD_IO) ?
                                   ST_FIELD : ST_DUMMY;
                    end
                end
                ST_FIELD: begin
                    if (phase_end) begin
                        cnt_q   <= 5'h0;
                        state_q <= (dummy_len == 5'h0) ?
                                   ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (phase_end) begin
                        cnt_q   <= 5'h0;
                        state_q <= ST_DATA;
                    end
                end
                default: cnt_q <= 5'h0;
            endcase
        end
    end

    // Lane input during dummy clocks is shifted but never used.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sh_q <= 24'h0;
        end else if (rise && cs_act) begin
            sh_q <= sh_n;
        end
    end

    // Ones on lane 0 during the field force its bit 4 high.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cont_q <= 1'b0;
        end else if (rise && cs_act && state_q == ST_FIELD && phase_end) begin
            cont_q <= (sh_n[5:4] == CONT_CODE);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            addr_q <= 24'h0;
        end else if (cs_act && rise && state_q == ST_ADDR && phase_end) begin
            addr_q <= sh_n;
        end else if (cs_act && fall && state_q == ST_DATA
                     && ocnt_q == 3'h0) begin
            addr_q <= next_addr(addr_q, wrap_on,
                                cfg_q.wrap_config_bits[2:1]);
        end
    end

    assign mem_addr_o = addr_q;

    // Driving starts only at a falling edge in the data phase, by
    // which time the host has let go of the lanes.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            io_q   <= 4'h0;
            oe_q   <= 4'h0;
            obuf_q <= 8'h0;
            ocnt_q <= 3'h0;
        end else if (!cs_act) begin
            oe_q   <= 4'h0;
            ocnt_q <= 3'h0;
        end else if (fall && state_q == ST_DATA) begin
            oe_q <= lane_mask(dl);
            if (ocnt_q == 3'h0) begin
                io_q   <= top_bits(mem_rdata_i, dl);
                obuf_q <= mem_rdata_i << dl;
            end else begin
                io_q   <= top_bits(obuf_q, dl);
                obuf_q <= obuf_q << dl;
            end
            if (ocnt_q == clks_for(FIELD_BITS, dl) - 5'h1) begin
                ocnt_q <= 3'h0;
            end else begin
                ocnt_q <= ocnt_q + 3'h1;
            end
        end
    end

    assign io_o    = io_q;
    assign io_oe_o = oe_q;

    assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
    assign rd_go = s_axi_arvalid_i & ~rvalid_q;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o  = wr_go;
    assign s_axi_arready_o = ~rvalid_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg_q    <= CFG_RST;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= RESP_OKAY;
            if ({s_axi_awaddr_i[7:2], 2'h0} == REG_CTRL) begin
                if (s_axi_wstrb_i[0]) begin
                    cfg_q.quad_lane_enable <= s_axi_wdata_i[CTRL_QE_BIT];
                    cfg_q.four_lane_command_mode <=
                        s_axi_wdata_i[CTRL_FOUR_BIT];
                    cfg_q.wrap_config_bits <=
                        s_axi_wdata_i[CTRL_WRAP_LSB+:3];
                end
                if (s_axi_wstrb_i[1]) begin
                    cfg_q.dummy_sel <= s_axi_wdata_i[CTRL_DSEL_LSB+:2];
                end
            end else if ({s_axi_awaddr_i[7:2], 2'h0} != REG_STAT) begin
                bresp_q <= RESP_DECERR;
            end
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    always_comb begin
        ctrl_w = 32'h0;
        ctrl_w[CTRL_QE_BIT]       = cfg_q.quad_lane_enable;
        ctrl_w[CTRL_FOUR_BIT]     = cfg_q.four_lane_command_mode;
        ctrl_w[CTRL_WRAP_LSB+:3]  = cfg_q.wrap_config_bits;
        ctrl_w[CTRL_DSEL_LSB+:2]  = cfg_q.dummy_sel;
        stat_w = 32'h0;
        stat_w[2:0]               = state_q;
        stat_w[STAT_CONT_BIT]     = cont_q;
        stat_w[STAT_ACT_BIT]      = cs_act;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0;
            if ({s_axi_araddr_i[7:2], 2'h0} == REG_CTRL) begin
                rdata_q <= ctrl_w;
            end else if ({s_axi_araddr_i[7:2], 2'h0} == REG_STAT) begin
                rdata_q <= stat_w;
            end else begin
                rresp_q <= RESP_DECERR;
            end
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o  = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o  = rresp_q;
    assign s_axi_rdata_o  = rdata_q;

endmodule
`default_nettype wire

// ===== testbench/mlf_read_path_checker.sv
`timescale 1ns/10ps
`default_nettype none
module mlf_read_path_checker (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    // Link pins
    input wire logic        sclk_i,
    input wire logic        cs_n_i,
    input wire logic [3:0]  io_o,
    input wire logic [3:0]  io_oe_o,
    // Register bus
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o
);
    import mlf_pkg::*;
    logic [3:0] cs_hi_q;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // Select-high age, saturating; the lanes get a few cycles to let go.
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !cs_n_i) begin
            cs_hi_q <= 4'h0;
        end else if (cs_hi_q != 4'hF) begin
            cs_hi_q <= cs_hi_q + 4'h1;
        end
    end
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp lost");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata lost");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=>
        s_axi_bvalid_o) else $error("write not answered");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o) else $error("read not answered");
    ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while answer pending");
    decerr_zero_a: assert property (s_axi_rvalid_o &&
        s_axi_rresp_o == RESP_DECERR |-> s_axi_rdata_o == 32'h0)
        else $error("decode error with data");
    lane_idle_a: assert property (cs_hi_q > 4'h6 |-> io_oe_o == 4'h0)
        else $error("lanes driven while deselected");
    lane_mask_a: assert property (io_oe_o != 4'h0 |->
        io_oe_o == 4'h3 || io_oe_o == 4'hF) else $error("bad lane mask");
    io_fall_a: assert property ($changed(io_o) && io_oe_o != 4'h0 &&
        $past(io_oe_o) != 4'h0 |-> $past(!sclk_i, 2))
        else $error("data changed away from a falling edge");
    cover property (io_oe_o == 4'h3);
    cover property (io_oe_o == 4'hF);
    cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_DECERR);
endmodule
bind mlf_read_path mlf_read_path_checker u_chk (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .io_o(io_o), .io_oe_o(io_oe_o),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o));
`default_nettype wire

// ===== testbench/mlf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mlf_host_model (
    // Clock
    input  wire logic       core_clk_i,
    // Lanes as seen on the wire
    input  wire logic [3:0] io_i,
    // Host drive
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic [3:0]      io_o,
    output logic [3:0]      io_oe_o
);
    logic [7:0] rx_q[$];
    initial begin
        sclk_o  = 1'b0;
        cs_n_o  = 1'b1;
        io_o    = 4'h0;
        io_oe_o = 4'h0;
    end
    // Four core cycles a phase give the 32 ns link clock.
    task automatic half(input logic lvl);
        sclk_o <= lvl;
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic open();
        cs_n_o <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask
    // Clock stops low outside frames.
    task automatic close();
        io_oe_o <= 4'h0;
        half(1'b0);
        cs_n_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic shift(input logic [31:0] v, input int n, input int w);
        for (int i = n - w; i >= 0; i -= w) begin
            io_oe_o <= 4'((1 << w) - 1);
            io_o    <= 4'((v >> i) & ((1 << w) - 1));
            half(1'b0);
            half(1'b1);
        end
    endtask
    // Data is taken late in the high phase, after the device has settled.
    task automatic read(input int dm, input int w, input int nb);
        logic [7:0] b;
        b = 8'h00;
        rx_q = {};
        io_oe_o <= 4'h0;
        @(posedge core_clk_i);
        repeat (dm) begin
            half(1'b0);
            half(1'b1);
        end
        repeat (nb) begin
            for (int i = 0; i < 8; i += w) begin
                half(1'b0);
                half(1'b1);
                b = 8'((b << w) | (io_i & 4'((1 << w) - 1)));
            end
            rx_q.push_back(b);
        end
    endtask
    task automatic leave(input int n);
        open();
        shift(32'hFFFF, n, 1);
        close();
    endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mlf_pkg::*;
    logic        clk, srst, tog, awvalid, wvalid, bready, arvalid, rready;
    logic        sclk, cs_n, awready, wready, bvalid, arready, rvalid;
    logic [3:0]  io_in, io_out, io_oe, h_io, h_oe, wstrb, oe_acc;
    logic [23:0] maddr;
    logic [7:0]  mdata, awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] d;
    int          num_errors, checked;
    initial begin
        {clk, tog, awvalid, wvalid, bready, arvalid, rready} = '0;
        {srst, awaddr, araddr, wdata, wstrb, mdata, oe_acc} = '0;
        seed = 32'h1664;
        num_errors = 0;
        checked = 0;
        forever #2 clk = ~clk;
    end
    // A released lane toggles so a stale level never reads as data.
    assign io_in = (io_oe & io_out) | (h_oe & h_io) | (~io_oe & ~h_oe & {4{tog}});
    always @(posedge clk) begin
        tog <= ~tog;
        mdata <= maddr[7:0] ^ maddr[15:8] ^ maddr[23:16] ^ 8'h5A;
        if (!cs_n) oe_acc <= oe_acc | io_oe;
    end
    mlf_host_model host (.core_clk_i(clk), .io_i(io_in), .sclk_o(sclk),
        .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe));
    mlf_read_path dut (.core_clk_i(clk), .srst_i(srst), .sclk_i(sclk),
        .cs_n_i(cs_n), .io_i(io_in), .io_o(io_out), .io_oe_o(io_oe),
        .mem_addr_o(maddr), .mem_rdata_i(mdata), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction
    function automatic logic [23:0] nxt(input logic [23:0] a, input int wl);
        if (wl == 0) return a + 24'h1;
        return (a & ~24'(wl - 1)) | ((a + 24'h1) & 24'(wl - 1));
    endfunction
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_byte(input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected data byte expected %h seen %h", e, g);
        end
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v,
                          input logic [3:0] st);
        int n;
        n = 0;
        awaddr <= ad;
        wdata <= v;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin @(posedge clk); n++; end while (!(awready && wready) && n < 99);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do begin @(posedge clk); n++; end while (!bvalid && n < 99);
        r = bresp;
        bready <= 1'b0;
        if (n >= 99) begin num_errors++; report_and_stop(); end
    endtask
    task automatic axi_rd(input logic [7:0] ad);
        int n;
        n = 0;
        araddr <= ad;
        arvalid <= 1'b1;
        do begin @(posedge clk); n++; end while (!arready && n < 99);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin @(posedge clk); n++; end while (!rvalid && n < 99);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 99) begin num_errors++; report_and_stop(); end
    endtask
    task automatic set_ctrl(input logic [31:0] v, input logic [3:0] st);
        axi_wr(REG_CTRL, v, st);
        chk_word("ctrl write response", 32'(RESP_OKAY), 32'(r));
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] m, e);
        axi_rd(ad);
        chk_word("register", e, d & m);
    endtask
    // One read frame at a random address; m is the lane mask to expect.
    task automatic xfer(input logic [7:0] op, input int ow, aw,
        input logic [7:0] f, input int dm, dw, nb, wl, input logic [3:0] m);
        logic [23:0] a;
        a = 24'(rnd());
        oe_acc <= 4'h0;
        host.open();
        if (ow != 0) host.shift(32'(op), 8, ow);
        host.shift(32'(a), 24, aw);
        if (aw > 1) host.shift(32'(f), 8, aw);
        host.read(dm, dw, nb);
        host.close();
        chk_word("lane mask", 32'(m), 32'(oe_acc));
        for (int i = 0; i < nb && m != 4'h0; i++) begin
            chk_byte(pat(a), host.rx_q[i]);
            a = nxt(a, wl);
        end
    endtask
    initial begin
        do_reset();
        rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h010);
        axi_rd(8'h08);
        chk_word("unmapped read", 32'h3, {d[29:0], r});
        axi_wr(8'h0C, 32'h1, 4'hF);
        chk_word("unmapped write", 32'(RESP_DECERR), 32'(r));
        xfer(OP_DUAL_OUT, 1, 1, 8'h0, 8, 2, 6, 0, 4'h3);
        xfer(OP_QUAD_OUT, 1, 1, 8'h0, 8, 4, 1, 0, 4'h0);
        xfer(OP_QUAD_IO, 1, 4, 8'h0, 4, 4, 1, 0, 4'h0);
        set_ctrl(32'h011, 4'hF);
        xfer(OP_QUAD_OUT, 1, 1, 8'h0, 8, 4, 5, 0, 4'hF);
        xfer(OP_DUAL_IO, 1, 2, 8'h20, 0, 2, 4, 0, 4'h3);
        rd_chk(REG_STAT, 32'h10, 32'h10);
        xfer(8'h0, 0, 2, 8'h2F, 0, 2, 4, 0, 4'h3);
        host.leave(16);
        rd_chk(REG_STAT, 32'h10, 32'h0);
        xfer(OP_DUAL_IO, 1, 2, 8'h0, 0, 2, 3, 0, 4'h3);
        xfer(OP_QUAD_IO, 1, 4, 8'h20, 4, 4, 4, 0, 4'hF);
        xfer(8'h0, 0, 4, 8'h10, 4, 4, 4, 0, 4'hF);
        xfer(OP_QUAD_IO, 1, 4, 8'hE0, 4, 4, 2, 0, 4'hF);
        host.leave(8);
        rd_chk(REG_STAT, 32'h10, 32'h0);
        for (int s = 0; s < 4; s++) begin
            set_ctrl(32'(1 | (s << 5)), 4'hF);
            xfer(OP_QUAD_IO, 1, 4, 8'h0, 4, 4, (8 << s) + 2, 8 << s, 4'hF);
        end
        set_ctrl(32'h3FF, 4'h1);
        rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h073);
        for (int k = 0; k < 4; k++) begin
            set_ctrl(32'(3 | (k << 8)), 4'hF);
            xfer(OP_QUAD_IO, 4, 4, 8'h0, 2 * k, 4, 10, 0, 4'hF);
        end
        xfer(OP_QUAD_OUT, 4, 1, 8'h0, 8, 4, 1, 0, 4'h0);
        xfer(OP_QUAD_IO, 4, 4, 8'h20, 6, 4, 3, 0, 4'hF);
        xfer(8'h0, 0, 4, 8'h0, 6, 4, 3, 0, 4'hF);
        do_reset();
        rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h010);
        report_and_stop();
    end
endmodule
`default_nettype wire
